// ==== rtl/gpio_bank_pkg.sv ====
`default_nettype none
package gpio_bank_pkg;

  localparam int PORT_W = 16;
  localparam int ADDR_W = 4;

  // Register offsets (word index on the plain register port)
  localparam logic [3:0] OFS_PB_PULLDOWN   = 4'h0;
  localparam logic [3:0] OFS_PC_DATA       = 4'h1;
  localparam logic [3:0] OFS_PC_PIN_LEVEL  = 4'h2;
  localparam logic [3:0] OFS_PC_INVERT     = 4'h3;
  localparam logic [3:0] OFS_PC_DRIVE      = 4'h4;
  localparam logic [3:0] OFS_PF_DATA       = 4'h5;
  localparam logic [3:0] OFS_PC_DIRECTION  = 4'h6;
  localparam logic [3:0] OFS_PF_DIRECTION  = 4'h7;

  localparam logic [15:0] REG_RESET     = 16'h0000;
  localparam logic [15:0] PB_PD_MASK    = 16'h000a;
  localparam logic [15:0] PC_DRIVE_MASK = 16'h0001;
  localparam logic [15:0] READ_ZERO     = 16'h0000;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Per-pin function steering from the pin-function controller
  typedef struct packed {
    logic [15:0] gen_out;
    logic [15:0] ext_bus;
    logic [15:0] periph_val;
  } pin_func_t;

endpackage
`default_nettype wire

// ==== rtl/pin_sync2.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_sync2 #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/gpio_port_bank_bcf.sv ====
// Functional notes
// R1: Port B pull-down bits 3 and 1 writable; 1 enables pull-down.
// R2: Other port B pull-down bits read 0; software writes 0.
// R3: Direction 1 and general output: data bit drives the pin.
// R4: Direction 0: data read returns pin level; writes stored only.
// R5: Direction 1: data read returns stored value.
// R6: Direction 1 but other function: writes stored, pin unaffected.
// R7: All writable registers reset to zero; sleep keeps contents.
// R8: Port C pin-level register read-only, returns pin levels.
// R9: Port C invert bit 1 drives complement of selected output value.
// R10: Port C invert ignored when pin carries external bus function.
// R11: Port C drive bit 0 set selects high drive, fast slew.
// R12: Port C drive bits 15..1 read 0; software writes 0.
// R13: Port C has 16 pins; bit n maps to pin n.
// R14: Port F data register behaves like port C data register.
// R15: Pin levels pass a two-stage synchroniser before being read.
// R16: Accesses take one bus cycle; pins update edge after write.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_bank_bcf #(
  parameter int W = gpio_bank_pkg::PORT_W
) (
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  input  wire logic                     clk_en,
  input  wire gpio_bank_pkg::reg_req_t  req,
  output logic [15:0]                   rdata,
  input  wire gpio_bank_pkg::pin_func_t pc_func,
  input  wire gpio_bank_pkg::pin_func_t pf_func,
  input  wire logic [W-1:0]             pc_pin_in,
  output logic [W-1:0]                  pc_pin_out,
  output logic [W-1:0]                  pc_pin_oe,
  input  wire logic [W-1:0]             pf_pin_in,
  output logic [W-1:0]                  pf_pin_out,
  output logic [W-1:0]                  pf_pin_oe,
  output logic [W-1:0]                  pb_pulldown_en,
  output logic                          pc_high_drive
);

  logic [15:0]  pb_pd_ff;
  logic [W-1:0] pc_data_ff;
  logic [W-1:0] pc_inv_ff;
  logic [15:0]  pc_drive_ff;
  logic [W-1:0] pf_data_ff;
  logic [W-1:0] pc_dir_ff;
  logic [W-1:0] pf_dir_ff;
  logic [W-1:0] pc_sync;
  logic [W-1:0] pf_sync;
  logic [15:0]  nxt_rdata;
  logic [W-1:0] nxt_pc_out;
  logic [W-1:0] nxt_pf_out;

  function automatic logic wr_hit(input gpio_bank_pkg::reg_req_t r, input logic [3:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // Direction selects stored value or synchronised level per bit
  function automatic logic [W-1:0] data_view(input logic [W-1:0] dir,
                                             input logic [W-1:0] stored,
                                             input logic [W-1:0] level);
    return (dir & stored) | (~dir & level);
  endfunction

  // Pin levels are asynchronous to ref_clk
  pin_sync2 #(.W(W)) u_pc_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .async_in (pc_pin_in),
    .sync_out (pc_sync)
  ); // [R15]

  pin_sync2 #(.W(W)) u_pf_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .async_in (pf_pin_in),
    .sync_out (pf_sync)
  ); // [R15]

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pb_pd_ff <= gpio_bank_pkg::REG_RESET; // [R7]
    end else if (clk_en && wr_hit(req, gpio_bank_pkg::OFS_PB_PULLDOWN)) begin
      pb_pd_ff <= req.wdata & gpio_bank_pkg::PB_PD_MASK; // [R1] [R2]
    end
  end

  // Data writes are stored whatever the direction; only the pin path filters
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_data_ff <= gpio_bank_pkg::REG_RESET[W-1:0]; // [R7]
    end else if (clk_en && wr_hit(req, gpio_bank_pkg::OFS_PC_DATA)) begin
      pc_data_ff <= req.wdata[W-1:0]; // [R4] [R6] [R13]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pf_data_ff <= gpio_bank_pkg::REG_RESET[W-1:0]; // [R7]
    end else if (clk_en && wr_hit(req, gpio_bank_pkg::OFS_PF_DATA)) begin
      pf_data_ff <= req.wdata[W-1:0]; // [R14]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_inv_ff <= gpio_bank_pkg::REG_RESET[W-1:0]; // [R7]
    end else if (clk_en && wr_hit(req, gpio_bank_pkg::OFS_PC_INVERT)) begin
      pc_inv_ff <= req.wdata[W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_drive_ff <= gpio_bank_pkg::REG_RESET; // [R7]
    end else if (clk_en && wr_hit(req, gpio_bank_pkg::OFS_PC_DRIVE)) begin
      pc_drive_ff <= req.wdata & gpio_bank_pkg::PC_DRIVE_MASK; // [R12]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_dir_ff <= gpio_bank_pkg::REG_RESET[W-1:0];
      pf_dir_ff <= gpio_bank_pkg::REG_RESET[W-1:0];
    end else if (clk_en) begin
      if (wr_hit(req, gpio_bank_pkg::OFS_PC_DIRECTION)) begin
        pc_dir_ff <= req.wdata[W-1:0];
      end
      if (wr_hit(req, gpio_bank_pkg::OFS_PF_DIRECTION)) begin
        pf_dir_ff <= req.wdata[W-1:0];
      end
    end
  end

  // Pin value: general-output pins take the data register, others the
  // peripheral's value; inversion is skipped on external bus pins.
  always_comb begin
    nxt_pc_out = (pc_func.gen_out & pc_data_ff)
               | (~pc_func.gen_out & pc_func.periph_val); // [R3] [R6]
    nxt_pc_out = nxt_pc_out ^ (pc_inv_ff & ~pc_func.ext_bus); // [R9] [R10]
    nxt_pf_out = (pf_func.gen_out & pf_data_ff)
               | (~pf_func.gen_out & pf_func.periph_val); // [R14]
  end

  // Outputs registered from the current register state, so a write
  // reaches the pin one edge after the register updates.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_pin_out     <= '0;
      pc_pin_oe      <= '0;
      pf_pin_out     <= '0;
      pf_pin_oe      <= '0;
      pb_pulldown_en <= '0;
      pc_high_drive  <= 1'b0;
    end else if (clk_en) begin
      pc_pin_out     <= nxt_pc_out; // [R16]
      pc_pin_oe      <= pc_dir_ff; // [R3]
      pf_pin_out     <= nxt_pf_out;
      pf_pin_oe      <= pf_dir_ff;
      pb_pulldown_en <= pb_pd_ff[W-1:0]; // [R1]
      pc_high_drive  <= pc_drive_ff[0]; // [R11]
    end
  end

  always_comb begin
    nxt_rdata = gpio_bank_pkg::READ_ZERO;
    if (req.addr == gpio_bank_pkg::OFS_PB_PULLDOWN) begin
      nxt_rdata = pb_pd_ff; // [R2]
    end else if (req.addr == gpio_bank_pkg::OFS_PC_DATA) begin
      nxt_rdata = data_view(pc_dir_ff, pc_data_ff, pc_sync); // [R4] [R5]
    end else if (req.addr == gpio_bank_pkg::OFS_PC_PIN_LEVEL) begin
      nxt_rdata = pc_sync; // [R8]
    end else if (req.addr == gpio_bank_pkg::OFS_PC_INVERT) begin
      nxt_rdata = pc_inv_ff;
    end else if (req.addr == gpio_bank_pkg::OFS_PC_DRIVE) begin
      nxt_rdata = pc_drive_ff; // [R12]
    end else if (req.addr == gpio_bank_pkg::OFS_PF_DATA) begin
      nxt_rdata = data_view(pf_dir_ff, pf_data_ff, pf_sync); // [R14]
    end else if (req.addr == gpio_bank_pkg::OFS_PC_DIRECTION) begin
      nxt_rdata = pc_dir_ff;
    end else if (req.addr == gpio_bank_pkg::OFS_PF_DIRECTION) begin
      nxt_rdata = pf_dir_ff;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= req.rd ? nxt_rdata : gpio_bank_pkg::READ_ZERO; // [R16]
    end
  end

  a_pb_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    (pb_pd_ff & ~gpio_bank_pkg::PB_PD_MASK) == 16'h0000)
    else $error("pull-down reserved bit set");

  a_drive_reserved: assert property (@(posedge ref_clk) disable iff (!nrst) // [R12]
    clk_en && wr_hit(req, gpio_bank_pkg::OFS_PC_DRIVE) |=> pc_drive_ff[15:1] == 15'h0000)
    else $error("drive reserved bit set");

  a_pc_write_pin: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
    clk_en && wr_hit(req, gpio_bank_pkg::OFS_PC_DATA) ##1 clk_en
      |=> pc_pin_out[0] == ($past(req.wdata[0], 2)
        ^ ($past(pc_inv_ff[0]) & ~$past(pc_func.ext_bus[0])))
        || !$past(pc_func.gen_out[0]))
    else $error("port C pin missed data write");

  a_pc_invert_out: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    clk_en && pc_func.gen_out[8] && !pc_func.ext_bus[8] && pc_inv_ff[8]
      |=> pc_pin_out[8] == !$past(pc_data_ff[8]))
    else $error("port C pin not inverted");

  a_ext_bus_noinv: assert property (@(posedge ref_clk) disable iff (!nrst) // [R10]
    clk_en && pc_func.ext_bus[8] && !pc_func.gen_out[8]
      |=> pc_pin_out[8] == $past(pc_func.periph_val[8]))
    else $error("inversion applied on bus pin");

  a_pc_read_input: assert property (@(posedge ref_clk) disable iff (!nrst) // [R4]
    clk_en && req.rd && req.addr == gpio_bank_pkg::OFS_PC_DATA && !pc_dir_ff[2]
      |=> rdata[2] == $past(pc_sync[2]))
    else $error("input pin read wrong");

  a_pc_read_output: assert property (@(posedge ref_clk) disable iff (!nrst) // [R5]
    clk_en && req.rd && req.addr == gpio_bank_pkg::OFS_PC_DATA && pc_dir_ff[3]
      |=> rdata[3] == $past(pc_data_ff[3]))
    else $error("output pin read wrong");

  a_level_readonly: assert property (@(posedge ref_clk) disable iff (!nrst) // [R8]
    clk_en && req.rd && req.addr == gpio_bank_pkg::OFS_PC_PIN_LEVEL
      |=> rdata == $past(pc_sync))
    else $error("pin level read wrong");

  a_pf_read_mix: assert property (@(posedge ref_clk) disable iff (!nrst) // [R14]
    clk_en && req.rd && req.addr == gpio_bank_pkg::OFS_PF_DATA
      |=> rdata == (($past(pf_dir_ff) & $past(pf_data_ff))
        | (~$past(pf_dir_ff) & $past(pf_sync))))
    else $error("port F data read wrong");

  a_sync_two_stage: assert property (@(posedge ref_clk) disable iff (!nrst) // [R15]
    clk_en ##1 clk_en |=> pc_sync == $past(pc_pin_in, 2))
    else $error("synchroniser depth wrong");

  a_high_drive: assert property (@(posedge ref_clk) disable iff (!nrst) // [R11]
    clk_en && wr_hit(req, gpio_bank_pkg::OFS_PC_DRIVE) ##1 clk_en
      |=> pc_high_drive == $past(req.wdata[0], 2))
    else $error("high drive not applied");

  a_rdata_quiet: assert property (@(posedge ref_clk) disable iff (!nrst) // [R16]
    clk_en && !req.rd |=> rdata == 16'h0000)
    else $error("read data outside read slot");

endmodule
`default_nettype wire

// ==== verif/pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] ext_lvl,
  output logic      [15:0] pin_in
);
  // A driven pin carries the port value; an undriven one the board level
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

// ==== verif/gpio_port_bank_bcf_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module gpio_port_bank_bcf_tb_top;
  logic                     ref_clk, nrst, clk_en, pc_hd;
  gpio_bank_pkg::reg_req_t  req;
  gpio_bank_pkg::pin_func_t pc_func, pf_func;
  logic [15:0]              rdata, pc_in, pc_out, pc_oe, pf_in, pf_out, pf_oe, pb_pd, pc_ext, pf_ext;
  int                       failures, n_checks;

  gpio_port_bank_bcf uut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .req(req),
    .rdata(rdata), .pc_func(pc_func), .pf_func(pf_func), .pc_pin_in(pc_in),
    .pc_pin_out(pc_out), .pc_pin_oe(pc_oe), .pf_pin_in(pf_in), .pf_pin_out(pf_out),
    .pf_pin_oe(pf_oe), .pb_pulldown_en(pb_pd), .pc_high_drive(pc_hd));
  pin_model pcm (.pin_out(pc_out), .pin_oe(pc_oe), .ext_lvl(pc_ext), .pin_in(pc_in));
  pin_model pfm (.pin_out(pf_out), .pin_oe(pf_oe), .ext_lvl(pf_ext), .pin_in(pf_in));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    chk($sformatf("register %h", a), exp, rdata);
  endtask
  task automatic report_and_stop;
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // The whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    req = '0;
    pc_func = '0;
    pf_func = '0;
    pc_ext = 16'h5a3c;
    pf_ext = 16'h00ff;
    failures = 0;
    n_checks = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(gpio_bank_pkg::OFS_PB_PULLDOWN, 16'h0000);
    rd(gpio_bank_pkg::OFS_PC_INVERT, 16'h0000);
    rd(gpio_bank_pkg::OFS_PC_DRIVE, 16'h0000);
    rd(gpio_bank_pkg::OFS_PC_DATA, 16'h5a3c);
    rd(gpio_bank_pkg::OFS_PC_PIN_LEVEL, 16'h5a3c);
    wr(gpio_bank_pkg::OFS_PB_PULLDOWN, 16'hffff);
    rd(gpio_bank_pkg::OFS_PB_PULLDOWN, 16'h000a);
    chk("pb_pulldown_en", 16'h000a, pb_pd);
    wr(gpio_bank_pkg::OFS_PC_DRIVE, 16'hffff);
    rd(gpio_bank_pkg::OFS_PC_DRIVE, 16'h0001);
    chk("pc_high_drive", 16'h0001, {15'h0000, pc_hd});
    wr(gpio_bank_pkg::OFS_PC_DATA, 16'h1234);
    rd(gpio_bank_pkg::OFS_PC_DATA, 16'h5a3c);
    wr(gpio_bank_pkg::OFS_PC_PIN_LEVEL, 16'hffff);
    rd(gpio_bank_pkg::OFS_PC_PIN_LEVEL, 16'h5a3c);
    @(posedge ref_clk);
    pc_func.gen_out <= 16'hffff;
    wr(gpio_bank_pkg::OFS_PC_DIRECTION, 16'hffff);
    tick(2);
    chk("pc_pin_out", 16'h1234, pc_out);
    chk("pc_pin_oe", 16'hffff, pc_oe);
    wr(gpio_bank_pkg::OFS_PC_INVERT, 16'hff00);
    tick(2);
    chk("pc_pin_out", 16'hed34, pc_out);
    rd(gpio_bank_pkg::OFS_PC_DATA, 16'h1234);
    rd(gpio_bank_pkg::OFS_PC_PIN_LEVEL, 16'hed34);
    @(posedge ref_clk);
    pc_func <= '{gen_out: 16'hf0ff, ext_bus: 16'h0f00, periph_val: 16'h0a00};
    tick(2);
    chk("pc_pin_out", 16'hea34, pc_out);
    wr(gpio_bank_pkg::OFS_PC_DATA, 16'hffff);
    tick(1);
    chk("pc_pin_out", 16'h0aff, pc_out);
    wr(gpio_bank_pkg::OFS_PF_DATA, 16'ha5a5);
    rd(gpio_bank_pkg::OFS_PF_DATA, 16'h00ff);
    @(posedge ref_clk);
    pf_func.gen_out <= 16'hffff;
    wr(gpio_bank_pkg::OFS_PF_DIRECTION, 16'hffff);
    tick(2);
    chk("pf_pin_out", 16'ha5a5, pf_out);
    chk("pf_pin_oe", 16'hffff, pf_oe);
    rd(gpio_bank_pkg::OFS_PF_DATA, 16'ha5a5);
    wr(4'h8, 16'hffff);
    rd(4'h8, 16'h0000);
    // A write while the clock enable is low must leave the register alone
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(gpio_bank_pkg::OFS_PC_INVERT, 16'h0000);
    clk_en <= 1'b1;
    rd(gpio_bank_pkg::OFS_PC_INVERT, 16'hff00);
    @(posedge ref_clk);
    nrst <= 1'b0;
    tick(2);
    @(posedge ref_clk);
    nrst <= 1'b1;
    rd(gpio_bank_pkg::OFS_PC_INVERT, 16'h0000);
    rd(gpio_bank_pkg::OFS_PB_PULLDOWN, 16'h0000);
    chk("pc_pin_oe", 16'h0000, pc_oe);
    chk("pc_pin_out", 16'h0a00, pc_out);
    report_and_stop();
  end
endmodule
`default_nettype wire
